// ---- src/gpio_port.sv ----
// Eight-pin GPIO port with AHB-Lite registers, pad control, pin mux and interrupts
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "gpio_cfg.svh"

module gpio_port import gpio_pkg::*;
#(
  parameter int NFUNC = 4
)
(
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic [7:0]         pin_in,
  output logic      [7:0]         pin_out,
  output logic      [7:0]         pin_oe,
  output logic      [7:0]         pin_pullup,
  output logic      [7:0]         pin_pulldown,
  output logic      [7:0]         pin_analog,
  output logic      [15:0]        pin_drive,
  output logic      [7:0]         periph_in,
  input  wire logic [NFUNC*8-1:0] periph_out,
  input  wire logic [NFUNC*8-1:0] periph_oe,
  output logic                    irq
);
  localparam int NP = `GPIO_NPINS;
  localparam int FW = (NFUNC > 1) ? $clog2(NFUNC) : 1;

  logic [7:0]    sync1;
  logic [7:0]    sync2;
  logic [7:0]    level;
  logic          ap_valid;
  logic          ap_write;
  logic [11:0]   ap_addr;
  logic          next_ap_valid;
  logic          next_ap_write;
  logic [11:0]   next_ap_addr;
  logic          accept;
  logic [31:0]   rd_val;
  logic [31:0]   next_hrdata;
  logic [7:0]    data_q;
  logic [7:0]    next_data;
  logic [7:0]    ie;
  logic [7:0]    next_ie;
  dir_mode_t     dir_q      [NP];
  dir_mode_t     next_dir   [NP];
  irq_type_t     itype_q    [NP];
  irq_type_t     next_itype [NP];
  drive_t        drv_q      [NP];
  drive_t        next_drv   [NP];
  pad_t          pad_q      [NP];
  pad_t          next_pad   [NP];
  logic [FW-1:0] func_q     [NP];
  logic [FW-1:0] next_func  [NP];
  logic [7:0]    raw;
  logic [7:0]    clr;
  logic [7:0]    in_mode;
  logic [7:0]    next_pin_out;
  logic [7:0]    next_pin_oe;
  logic [7:0]    wr_mask;
  logic          wr_cmd;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign accept    = hsel && htrans[1] && hready;
  // Analog pads have their digital input switched off
  assign level     = sync2 & ~pin_analog;
  assign periph_in = level;
  assign irq       = |(raw & ie);
  assign wr_cmd    = ap_valid && ap_write;
  assign wr_mask   = hwdata[`FLD_MASK_LSB +: 8];

  // Register read mux, sampled in the address phase
  always_comb
  begin
    rd_val = `RST_HRDATA;
    if (haddr[11:10] == 2'b00)
      rd_val[7:0] = level & haddr[9:2];
    else
      case (haddr[11:0])
        `OFS_DIRMODE:
          for (int i = 0; i < NP; i++) rd_val[2*i +: 2] = dir_q[i];
        `OFS_IRQTYPE:
          for (int i = 0; i < NP; i++) rd_val[3*i +: 3] = itype_q[i];
        `OFS_DRIVE:
          for (int i = 0; i < NP; i++) rd_val[2*i +: 2] = drv_q[i];
        `OFS_PADTYPE:
          for (int i = 0; i < NP; i++) rd_val[3*i +: 3] = pad_q[i];
        `OFS_FUNCSEL:
          for (int i = 0; i < NP; i++) rd_val[4*i +: FW] = func_q[i];
        `OFS_IE_SET:        rd_val[7:0] = ie;
        `OFS_IE_CLR:        rd_val[7:0] = ie;
        `OFS_RAW_STATUS:    rd_val[7:0] = raw;
        `OFS_MASKED_STATUS: rd_val[7:0] = raw & ie;
        default:            rd_val = `RST_HRDATA;
      endcase
  end

  always_comb
  begin
    next_ap_valid = accept;
    next_ap_write = accept && hwrite;
    next_ap_addr  = accept ? haddr[11:0] : ap_addr;
    next_hrdata   = (accept && !hwrite) ? rd_val : hrdata;
    next_data     = data_q;
    next_ie       = ie;
    clr           = 8'h00;
    next_dir      = dir_q;
    next_itype    = itype_q;
    next_drv      = drv_q;
    next_pad      = pad_q;
    next_func     = func_q;
    if (wr_cmd && ap_addr[11:10] == 2'b00)
      next_data = (data_q & ~ap_addr[9:2]) | (hwdata[7:0] & ap_addr[9:2]);
    else if (wr_cmd)
      case (ap_addr)
        `OFS_IE_SET:     next_ie = ie | wr_mask;
        `OFS_IE_CLR:     next_ie = ie & ~wr_mask;
        `OFS_RAW_STATUS: clr = hwdata[7:0];
        default:
          for (int i = 0; i < NP; i++)
            if (wr_mask[i])
              case (ap_addr)
                `OFS_DIRMODE: next_dir[i] = dir_mode_t'(hwdata[`FLD_VALUE_LSB +: 2]);
                `OFS_IRQTYPE: next_itype[i] = irq_type_t'(hwdata[`FLD_VALUE_LSB +: 3]);
                `OFS_DRIVE:   next_drv[i] = drive_t'(hwdata[`FLD_VALUE_LSB +: 2]);
                `OFS_PADTYPE: next_pad[i] = pad_t'(hwdata[`FLD_VALUE_LSB +: 3]);
                `OFS_FUNCSEL: next_func[i] = hwdata[`FLD_VALUE_LSB +: FW];
                default:      next_func[i] = func_q[i];
              endcase
      endcase
  end

  // Pin drive: the mux index selects exactly one function per pin
  always_comb
  begin
    int   idx;
    logic val;
    logic en;
    idx          = 0;
    val          = 1'b0;
    en           = 1'b0;
    next_pin_out = 8'h00;
    next_pin_oe  = 8'h00;
    for (int i = 0; i < NP; i++)
    begin
      idx = int'(func_q[i]) * 8 + i;
      val = data_q[i];
      en  = 1'b0;
      case (dir_q[i])
        dir_sw_output:        en = 1'b1;
        dir_peripheral_owned:
        begin
          val = periph_out[idx];
          en  = periph_oe[idx];
        end
        default:              en = 1'b0;
      endcase
      case (pad_q[i])
        pad_open_drain, pad_open_drain_pullup, pad_open_drain_pulldown:
        begin
          next_pin_out[i] = 1'b0;
          next_pin_oe[i]  = en && !val;
        end
        pad_analog:
        begin
          next_pin_out[i] = 1'b0;
          next_pin_oe[i]  = 1'b0;
        end
        default:
        begin
          next_pin_out[i] = val;
          next_pin_oe[i]  = en;
        end
      endcase
      in_mode[i] = (dir_q[i] == dir_sw_input);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1        <= 8'h00;
      sync2        <= 8'h00;
      ap_valid     <= 1'b0;
      ap_write     <= 1'b0;
      ap_addr      <= 12'h000;
      hrdata       <= `RST_HRDATA;
      data_q       <= `RST_DATA;
      ie           <= `RST_IE;
      pin_out      <= 8'h00;
      pin_oe       <= 8'h00;
      pin_pullup   <= 8'h00;
      pin_pulldown <= 8'h00;
      pin_analog   <= 8'h00;
      pin_drive    <= 16'h0000;
      for (int i = 0; i < NP; i++)
      begin
        dir_q[i]   <= dir_sw_input;
        itype_q[i] <= irq_falling;
        drv_q[i]   <= drive_low;
        pad_q[i]   <= pad_push_pull;
        func_q[i]  <= '0;
      end
    end
    else
    begin
      sync1    <= pin_in;
      sync2    <= sync1;
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_addr  <= next_ap_addr;
      hrdata   <= next_hrdata;
      data_q   <= next_data;
      ie       <= next_ie;
      pin_out  <= next_pin_out;
      pin_oe   <= next_pin_oe;
      dir_q    <= next_dir;
      itype_q  <= next_itype;
      drv_q    <= next_drv;
      pad_q    <= next_pad;
      func_q   <= next_func;
      for (int i = 0; i < NP; i++)
      begin
        // Pulls act on input pins too; drive only matters once the pin drives
        pin_pullup[i]   <= pad_q[i] inside {pad_push_pull_pullup, pad_open_drain_pullup};
        pin_pulldown[i] <= pad_q[i] inside {pad_push_pull_pulldown, pad_open_drain_pulldown};
        pin_analog[i]   <= pad_q[i] == pad_analog;
        pin_drive[2*i +: 2] <= drv_q[i];
      end
    end
  end

  // Status bits; software keeps pins still while retyping to avoid a false edge
  for (genvar g = 0; g < NP; g++)
  begin : g_irq
    gpio_pin_irq u_irq (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .level    (level[g]),
      .irq_type (itype_q[g]),
      .clear    (clr[g]),
      .status   (raw[g])
    );
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_data_write_mask: assert property (
    wr_cmd && ap_addr[11:10] == 2'b00 |=>
      ((data_q ^ $past(data_q)) & ~$past(ap_addr[9:2])) == 8'h00 &&
      (data_q & $past(ap_addr[9:2])) == ($past(hwdata[7:0]) & $past(ap_addr[9:2])))
    else $error("data write touched unselected pins");
  chk_read_masked: assert property (
    accept && !hwrite && haddr[11:10] == 2'b00 |=>
      (hrdata[7:0] & ~$past(haddr[9:2])) == 8'h00 && hrdata[31:8] == 24'h00_0000)
    else $error("data read leaks unselected pins");
  chk_status_upper: assert property (
    accept && !hwrite && haddr[11:0] == `OFS_MASKED_STATUS |=>
      hrdata[31:8] == 24'h00_0000 && hrdata[7:0] == $past(raw & ie))
    else $error("masked status read wrong");
  chk_enable_sel: assert property (wr_cmd && ap_addr == `OFS_IE_SET |=>
      ie == ($past(ie) | $past(wr_mask)))
    else $error("enable changed other pins");
  chk_disable_sel: assert property (wr_cmd && ap_addr == `OFS_IE_CLR |=>
      ie == ($past(ie) & ~$past(wr_mask)))
    else $error("disable changed other pins");
  chk_irq_follows: assert property (|(raw & ie) |-> irq ##0 (!irq || |(raw & ie)))
    else $error("interrupt output disagrees with masked status");
  chk_input_no_drive: assert property (1'b1 |=> (pin_oe & $past(in_mode)) == 8'h00)
    else $error("input pin driven");
  chk_pad_readback: assert property (
    wr_cmd && ap_addr == `OFS_PADTYPE && wr_mask[6] ##1 !wr_cmd ##1 accept && !hwrite &&
      haddr[11:0] == `OFS_PADTYPE |=> hrdata[20:18] == $past(hwdata[10:8], 3))
    else $error("pad type read back differs");

  cov_data_write: cover property (wr_cmd && ap_addr[11:10] == 2'b00);
  cov_irq_rise:   cover property ($rose(irq));
  cov_periph_pin: cover property (dir_q[0] == dir_peripheral_owned && pin_oe[0]);
  cov_clear_irq:  cover property (irq && |clr ##1 !irq);
endmodule // gpio_port

// ---- src/gpio_cfg.svh ----
// Register offsets, field positions and reset values of the GPIO port
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

`define GPIO_NPINS        8
// Byte addresses; 0x000-0x3FC is the data window, haddr[9:2] is the pin mask
`define OFS_DIRMODE       12'h400
`define OFS_IRQTYPE       12'h404
`define OFS_DRIVE         12'h408
`define OFS_PADTYPE       12'h40C
`define OFS_IE_SET        12'h410
`define OFS_IE_CLR        12'h414
`define OFS_RAW_STATUS    12'h418
`define OFS_MASKED_STATUS 12'h41C
`define OFS_FUNCSEL       12'h420

// Command write layout: [7:0] pin_select_mask, value from bit 8 upward
`define FLD_MASK_LSB      0
`define FLD_VALUE_LSB     8

`define RST_DATA          8'h00
`define RST_IE            8'h00
`define RST_HRDATA        32'h0000_0000
`endif

// ---- src/gpio_pkg.sv ----
// Types shared by the GPIO port modules
package gpio_pkg;

  typedef enum logic [1:0] {
    dir_sw_input         = 2'b00,
    dir_sw_output        = 2'b01,
    dir_peripheral_owned = 2'b10
  } dir_mode_t;

  typedef enum logic [2:0] {
    irq_falling = 3'b000,
    irq_rising  = 3'b001,
    irq_both    = 3'b010,
    irq_low     = 3'b011,
    irq_high    = 3'b100
  } irq_type_t;

  typedef enum logic [1:0] {
    drive_low               = 2'b00,
    drive_mid               = 2'b01,
    drive_high              = 2'b10,
    drive_high_slew_limited = 2'b11
  } drive_t;

  typedef enum logic [2:0] {
    pad_push_pull           = 3'b000,
    pad_push_pull_pullup    = 3'b001,
    pad_push_pull_pulldown  = 3'b010,
    pad_open_drain          = 3'b011,
    pad_open_drain_pullup   = 3'b100,
    pad_open_drain_pulldown = 3'b101,
    pad_analog              = 3'b110
  } pad_t;

endpackage

// ---- src/gpio_pin_irq.sv ----
// Interrupt detector for one pin
`timescale 1ns/10ps
module gpio_pin_irq import gpio_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      nrst,
  input  wire logic      level,
  input  irq_type_t      irq_type,
  input  wire logic      clear,
  output logic           status
);
  logic prev;
  logic next_prev;
  logic next_status;
  logic hit;
  logic is_level;
  logic match;

  always_comb
  begin
    is_level = (irq_type == irq_low) || (irq_type == irq_high);
    match    = (irq_type == irq_high) ? level : !level;
    case (irq_type)
      irq_falling: hit = prev && !level;
      irq_rising:  hit = !prev && level;
      irq_both:    hit = prev != level;
      default:     hit = 1'b0;
    endcase
    // Level status tracks the pin; edge status sticks, and a new edge beats a clear
    if (is_level)
      next_status = match;
    else
      next_status = hit || (status && !clear);
    next_prev = level;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      prev   <= 1'b0;
      status <= 1'b0;
    end
    else
    begin
      prev   <= next_prev;
      status <= next_status;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_edge_sticky: assert property (!is_level && status && !clear |=> status)
    else $error("edge status dropped without clear");
  chk_rise_sets: assert property (irq_type == irq_rising && !prev && level |=> status)
    else $error("rising edge not latched");
  chk_level_follow: assert property (is_level && $stable(irq_type) |=> status == $past(match))
    else $error("level status does not follow pin");
endmodule // gpio_pin_irq

// ---- test/pin_pad_model.sv ----
// Pad and board model that resolves each pin's level for the port's input
`timescale 1ns/10ps
module pin_pad_model
(
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] pin_pulldown,
  input  wire logic [7:0] ext,
  output logic      [7:0] pin_in
);
  // Own drive wins, then weak pulls, then whatever the board puts on the line
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (pin_pullup[i])
        pin_in[i] = 1'b1;
      else if (pin_pulldown[i])
        pin_in[i] = 1'b0;
      else
        pin_in[i] = ext[i];
    end
  end
endmodule // pin_pad_model

// ---- test/test_gpio_port_pin_control.sv ----
// Self-checking bench for the GPIO port over AHB-Lite
`timescale 1ns/10ps
`include "gpio_cfg.svh"
module test_gpio_port_pin_control;
  logic        clk_sys;
  logic        nrst;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, periph_out, periph_oe;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, pin_pulldown, pin_analog, periph_in, ext;
  logic [15:0] pin_drive;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [4:0]  exp_hi = 5'b10110;
  logic [4:0]  exp_lo = 5'b01101;

  gpio_port #(.NFUNC(4)) dut (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown),
    .pin_analog(pin_analog), .pin_drive(pin_drive), .periph_in(periph_in),
    .periph_out(periph_out), .periph_oe(periph_oe), .irq(irq));

  pin_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .pin_pulldown(pin_pulldown), .ext(ext), .pin_in(pin_in));

  task complete_run;
    $display("Mismatches %0d, comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask

  task cmd(input logic [31:0] a, input logic [7:0] mask, input logic [23:0] val);
    bus(1'b1, a, {val, mask});
  endtask

  task rchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task t_reset;
    logic [31:0] regs [8];
    regs = '{`OFS_DIRMODE, `OFS_IRQTYPE, `OFS_DRIVE, `OFS_PADTYPE, `OFS_IE_SET,
             `OFS_RAW_STATUS, `OFS_FUNCSEL, 32'h0000_0500};
    foreach (regs[i]) rchk(regs[i], 32'h0000_0000);
    chk({24'h0, pin_oe}, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  task t_output;
    cmd(`OFS_DIRMODE, 8'h0F, 24'h00_0001);
    rchk(`OFS_DIRMODE, 32'h0000_0055);
    bus(1'b1, {22'h0, 8'hFF, 2'b00}, 32'h0000_00A5);
    repeat (3) @(posedge clk_sys);
    chk({24'h0, pin_oe}, 32'h0000_000F);
    chk({24'h0, pin_out & pin_oe}, 32'h0000_0005);
    // Mask in the address clears pins 0 and 1 only
    bus(1'b1, {22'h0, 8'h03, 2'b00}, 32'h0000_0000);
    ext <= 8'hF0;
    repeat (6) @(posedge clk_sys);
    chk({24'h0, pin_out & pin_oe}, 32'h0000_0004);
    rchk({22'h0, 8'h0C, 2'b00}, 32'h0000_0004);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask

  task t_periph;
    cmd(`OFS_DIRMODE, 8'h04, 24'h00_0002);
    cmd(`OFS_FUNCSEL, 8'h04, 24'h00_0001);
    periph_oe  <= 32'h0000_0404;
    periph_out <= 32'h0000_0400;
    repeat (3) @(posedge clk_sys);
    chk({24'h0, pin_oe & 8'h04}, 32'h0000_0004);
    chk({24'h0, pin_out & 8'h04}, 32'h0000_0004);
    periph_out <= 32'h0000_0004;
    repeat (3) @(posedge clk_sys);
    chk({24'h0, pin_out & 8'h04}, 32'h0000_0000);
  endtask

  task t_pad;
    cmd(`OFS_DIRMODE, 8'hFF, 24'h00_0000);
    ext <= 8'h00;
    for (int d = 0; d < 4; d++) cmd(`OFS_DRIVE, 8'h01 << d, 24'(d));
    for (int p = 0; p < 7; p++) cmd(`OFS_PADTYPE, 8'h01 << p, 24'(p));
    // Read straight after the pin 6 write so the readback assertion is reached
    rchk(`OFS_PADTYPE, 32'h001A_C688);
    rchk(`OFS_DRIVE, 32'h0000_00E4);
    chk({16'h0, pin_drive}, 32'h0000_00E4);
    chk({pin_analog, pin_pulldown, pin_pullup}, 32'h0040_2412);
    repeat (5) @(posedge clk_sys);
    // Input pins: only the pulls show in what is read
    rchk({22'h0, 8'hFF, 2'b00}, 32'h0000_0012);
    chk({24'h0, periph_in}, 32'h0000_0012);
  endtask

  task t_irq;
    for (int t = 0; t < 5; t++)
    begin
      // Pin 7 is held still while its trigger type changes
      cmd(`OFS_IRQTYPE, 8'h80, 24'(t));
      rchk(`OFS_IRQTYPE, t << 21);
      // Clear every pin: earlier scenarios left falling edges latched on pins 0, 2 and 4 to 7
      bus(1'b1, `OFS_RAW_STATUS, 32'h0000_00FF);
      ext[7] <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rchk(`OFS_RAW_STATUS, {24'h0, exp_hi[t], 7'h0});
      bus(1'b1, `OFS_RAW_STATUS, 32'h0000_0080);
      ext[7] <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rchk(`OFS_RAW_STATUS, {24'h0, exp_lo[t], 7'h0});
    end
  endtask

  task t_mask;
    cmd(`OFS_IRQTYPE, 8'h80, 24'h00_0002);
    bus(1'b1, `OFS_RAW_STATUS, 32'h0000_0080);
    ext[7] <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0000_0000);
    bus(1'b1, `OFS_IE_SET, 32'h0000_0081);
    bus(1'b1, `OFS_IE_CLR, 32'h0000_0001);
    rchk(`OFS_IE_SET, 32'h0000_0080);
    chk({31'h0, irq}, 32'h0000_0001);
    rchk(`OFS_MASKED_STATUS, 32'h0000_0080);
    bus(1'b1, `OFS_RAW_STATUS, 32'h0000_0040);
    rchk(`OFS_RAW_STATUS, 32'h0000_0080);
    bus(1'b1, `OFS_IE_CLR, 32'h0000_0080);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0000_0000);
    rchk(`OFS_MASKED_STATUS, 32'h0000_0000);
    bus(1'b1, `OFS_IE_SET, 32'h0000_0080);
    // Clear early in the handler, then confirm the line dropped
    bus(1'b1, `OFS_RAW_STATUS, 32'h0000_0080);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0000_0000);
    rchk(`OFS_RAW_STATUS, 32'h0000_0000);
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Whole run is about 300 cycles; this ceiling only catches a hang
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      complete_run;
    end
  end

  initial
  begin
    nrst       = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0000_0000;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hwdata     = 32'h0000_0000;
    ext        = 8'h00;
    periph_out = 32'h0000_0000;
    periph_oe  = 32'h0000_0000;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset;
    t_output;
    t_periph;
    t_pad;
    t_irq;
    t_mask;
    complete_run;
  end
endmodule // test_gpio_port_pin_control
